// ==== include/cbs_pkg.sv ====
// shared constants, register map and carrier types of the channel block sequencer
package cbs_pkg;
	localparam int PC_W    = 12;
	localparam int GREG_W  = 8;
	localparam int ADDR_W  = 24;
	localparam int RANGE_W = 16;
	localparam int CNT_W   = 5;
	localparam int PCNT_W  = 4;

	localparam logic [CNT_W-1:0]  RUN_LIMIT    = 5'h1f;
	localparam logic [PCNT_W-1:0] PAUSE_CYCLES = 4'h4;
	localparam logic [PC_W-1:0]   PC_STEP      = 12'h001;

	localparam logic [5:0] OFS_CTRL      = 6'h00;
	localparam logic [5:0] OFS_STAT      = 6'h04;
	localparam logic [5:0] OFS_NEXT_ADDR = 6'h08;
	localparam logic [5:0] OFS_NEXT_CTL  = 6'h0c;
	localparam logic [5:0] OFS_ACT_ADDR  = 6'h10;
	localparam logic [5:0] OFS_ACT_RANGE = 6'h14;
	localparam logic [5:0] OFS_CB_STATUS = 6'h18;
	localparam logic [5:0] OFS_START_PC  = 6'h1c;
	localparam logic [5:0] OFS_CONTEXT   = 6'h20;
	localparam logic [5:0] OFS_LT_BYTES  = 6'h24;

	localparam int CTRL_START   = 0;
	localparam int CTRL_STOP    = 1;
	localparam int CTRL_SCAN    = 2;
	localparam int CTRL_ST_CCP  = 3;
	localparam int NCTL_VALID   = 16;
	localparam int NCTL_LAST    = 17;
	localparam int CTX_GREG     = 16;
	localparam int CTX_EQUAL    = 24;
	localparam int CTX_LASTCHR  = 25;
	localparam int LT_PARTNER   = 8;
	localparam int ST1_COMPLETE = 3;
	localparam int ST2_RESIDUE  = 2;
	localparam int ST2_BADADDR  = 5;
	localparam int ST2_PARITY   = 6;
	localparam int ST2_UNCORR   = 7;

	localparam logic [7:0] REASON_MASK  = 8'h60;
	localparam logic [7:0] PARTNER_MASK = 8'hc0;
	localparam logic [7:0] BYTE_RESET   = 8'h00;

	typedef enum logic [2:0] {
		CBS_IDLE  = 3'b001,
		CBS_RUN   = 3'b010,
		CBS_PAUSE = 3'b100
	} cbs_mode_t;

	typedef enum logic [3:0] {
		OP_STEP      = 4'h0,
		OP_LOAD      = 4'h1,
		OP_STORE     = 4'h2,
		OP_GET_NEXT  = 4'h3,
		OP_WAIT      = 4'h4,
		OP_CALL      = 4'h5,
		OP_RETURN    = 4'h6,
		OP_MARK      = 4'h7,
		OP_KICK      = 4'h8
	} cbs_op_t;

	typedef struct packed {
		logic              done;
		cbs_op_t           op;
		logic [PC_W-1:0]   next_pc;
		logic [GREG_W-1:0] greg;
		logic              equal;
		logic [7:0]        data;
	} cbs_exec_t;

	typedef struct packed {
		logic [PC_W-1:0]   pc;
		logic [GREG_W-1:0] greg;
		logic              equal;
		logic              last_char;
	} cbs_ctx_t;

	typedef struct packed {
		logic [ADDR_W-1:0]  addr;
		logic [RANGE_W-1:0] range;
		logic               valid;
		logic               last_block;
	} cbs_block_t;

	typedef struct packed {
		logic bad_addr;
		logic parity;
		logic uncorrected;
		logic rx_terminate;
	} cbs_fault_t;
endpackage

// ==== verilog/cbs_sequencer.sv ====
// channel block sequencer: active control block, program start/pause/wait and Avalon-MM registers
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module cbs_sequencer (
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	// avalon-mm slave
	input  wire logic [5:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	// instruction executor
	input  wire cbs_pkg::cbs_exec_t         exec,
	output logic                            run,
	output cbs_pkg::cbs_ctx_t               run_ctx,
	output logic                            cb_valid,
	output logic                            cb_last_block,
	// data mover and adapter
	input  wire logic                       is_receive,
	input  wire logic                       char_moved,
	input  wire cbs_pkg::cbs_fault_t        fault,
	input  wire logic                       adapter_req,
	input  wire logic                       status_change,
	input  wire logic                       partner_start,
	output logic                            partner_kick,
	output logic      [7:0]                 line_register_two
);
	typedef struct packed {
		cbs_pkg::cbs_mode_t          mode;
		logic [cbs_pkg::CNT_W-1:0]   cnt;
		logic [cbs_pkg::PCNT_W-1:0]  pcnt;
		cbs_pkg::cbs_ctx_t           ctx;
		cbs_pkg::cbs_ctx_t           saved;
		logic [cbs_pkg::PC_W-1:0]    start_pc;
		logic                        started;
		logic [cbs_pkg::PC_W-1:0]    ret_pc;
		logic                        call_act;
		cbs_pkg::cbs_block_t         act;
		cbs_pkg::cbs_block_t         nxt;
		logic [7:0]                  st1;
		logic [7:0]                  st2;
		logic                        scan_en;
		logic                        start_on_status;
		logic [7:0]                  reason;
		logic [7:0]                  partner;
		logic                        kick;
		logic                        waitreq;
		logic [31:0]                 rdata;
		logic                        run;
		logic                        last_shown;
	} cbs_state_t;

	cbs_state_t s;
	cbs_state_t next_s;

	// read view of the state; also the base that byte-lane merges on write start from
	function automatic logic [31:0] regval(input cbs_state_t v, input logic [5:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			cbs_pkg::OFS_CTRL: begin
				r[cbs_pkg::CTRL_SCAN]   = v.scan_en;
				r[cbs_pkg::CTRL_ST_CCP] = v.start_on_status;
			end
			cbs_pkg::OFS_STAT: begin
				r[2:0]   = v.mode;
				r[4]     = v.act.valid;
				r[5]     = v.act.last_block;
				r[6]     = v.ctx.last_char;
				r[7]     = v.nxt.valid;
				r[12:8]  = v.cnt;
				r[13]    = v.call_act;
			end
			cbs_pkg::OFS_NEXT_ADDR: r[cbs_pkg::ADDR_W-1:0] = v.nxt.addr;
			cbs_pkg::OFS_NEXT_CTL: begin
				r[cbs_pkg::RANGE_W-1:0]  = v.nxt.range;
				r[cbs_pkg::NCTL_VALID]   = v.nxt.valid;
				r[cbs_pkg::NCTL_LAST]    = v.nxt.last_block;
			end
			cbs_pkg::OFS_ACT_ADDR:  r[cbs_pkg::ADDR_W-1:0] = v.act.addr;
			cbs_pkg::OFS_ACT_RANGE: r[cbs_pkg::RANGE_W-1:0] = v.act.range;
			cbs_pkg::OFS_CB_STATUS: r[15:0] = {v.st2, v.st1};
			cbs_pkg::OFS_START_PC:  r[cbs_pkg::PC_W-1:0] = v.start_pc;
			cbs_pkg::OFS_CONTEXT: begin
				r[cbs_pkg::PC_W-1:0]             = v.saved.pc;
				r[cbs_pkg::CTX_GREG +: cbs_pkg::GREG_W] = v.saved.greg;
				r[cbs_pkg::CTX_EQUAL]            = v.saved.equal;
				r[cbs_pkg::CTX_LASTCHR]          = v.saved.last_char;
			end
			cbs_pkg::OFS_LT_BYTES: r[15:0] = {v.partner, v.reason};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	always_comb begin
		logic [31:0]                  mask;
		logic [31:0]                  wv;
		logic                         host_start;
		logic                         host_stop;
		logic                         complete;
		logic                         get_next;
		logic                         start_any;
		logic [7:0]                   err2;
		logic [cbs_pkg::RANGE_W-1:0]  new_range;
		mask       = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wv         = (regval(s, avs_address) & ~mask) | (avs_writedata & mask);
		host_start = 1'b0;
		host_stop  = 1'b0;
		complete   = 1'b0;
		get_next   = 1'b0;
		start_any  = 1'b0;
		err2       = 8'h00;
		new_range  = s.act.range;
		next_s     = s;
		next_s.kick = 1'b0;

		// one wait state: the answer stands at the second edge of every request
		next_s.waitreq = !((avs_read || avs_write) && s.waitreq);
		if ((avs_read || avs_write) && s.waitreq) begin
			next_s.rdata = avs_read ? regval(s, avs_address) : 32'h0000_0000;
		end
		if (avs_write && !s.waitreq) begin
			case (avs_address)
				cbs_pkg::OFS_CTRL: begin
					// start and stop are pulses; only the two enables are kept
					host_start             = wv[cbs_pkg::CTRL_START];
					host_stop              = wv[cbs_pkg::CTRL_STOP];
					next_s.scan_en         = wv[cbs_pkg::CTRL_SCAN];
					next_s.start_on_status = wv[cbs_pkg::CTRL_ST_CCP];
				end
				cbs_pkg::OFS_NEXT_ADDR: next_s.nxt.addr = wv[cbs_pkg::ADDR_W-1:0];
				cbs_pkg::OFS_NEXT_CTL: begin
					next_s.nxt.range      = wv[cbs_pkg::RANGE_W-1:0];
					next_s.nxt.valid      = wv[cbs_pkg::NCTL_VALID];
					next_s.nxt.last_block = wv[cbs_pkg::NCTL_LAST];
				end
				cbs_pkg::OFS_CB_STATUS: begin
					// completion later in this process overrides the clear
					next_s.st1 = cbs_pkg::BYTE_RESET;
					next_s.st2 = cbs_pkg::BYTE_RESET;
				end
				cbs_pkg::OFS_START_PC: next_s.start_pc = wv[cbs_pkg::PC_W-1:0];
				cbs_pkg::OFS_CONTEXT: begin
					// the saved context may only be altered while the program is stopped
					if (s.mode == cbs_pkg::CBS_IDLE) begin
						next_s.saved.pc        = wv[cbs_pkg::PC_W-1:0];
						next_s.saved.greg      = wv[cbs_pkg::CTX_GREG +: cbs_pkg::GREG_W];
						next_s.saved.equal     = wv[cbs_pkg::CTX_EQUAL];
						next_s.saved.last_char = wv[cbs_pkg::CTX_LASTCHR];
					end
				end
				cbs_pkg::OFS_LT_BYTES: begin
					next_s.reason  = wv[7:0];
					next_s.partner = wv[15:8];
				end
				default: ;
			endcase
		end

		// character movement and buffer faults
		// faults outside a live block have nothing to complete and are dropped
		if (s.act.valid) begin
			if (char_moved) begin
				next_s.act.addr = s.act.addr + {{(cbs_pkg::ADDR_W-1){1'b0}}, 1'b1};
			end
			if (fault.bad_addr) begin
				err2[cbs_pkg::ST2_BADADDR] = 1'b1;
				complete = 1'b1;
			end
			if (fault.parity) begin
				err2[cbs_pkg::ST2_PARITY] = 1'b1;
				complete = 1'b1;
			end
			if (fault.uncorrected) begin
				err2[cbs_pkg::ST2_UNCORR] = 1'b1;
				complete = 1'b1;
			end
			if (fault.rx_terminate && is_receive) begin
				err2[cbs_pkg::ST2_RESIDUE] = (s.act.range != '0);
				complete = 1'b1;
			end
			if (host_stop) begin
				complete = 1'b1;
			end
		end

		case (s.mode)
			cbs_pkg::CBS_IDLE: begin
				// starts are only seen while stopped; one raised during a pause is dropped
				start_any = adapter_req || host_start || partner_start
					|| (status_change && s.scan_en && s.start_on_status);
				if (start_any) begin
					next_s.mode = cbs_pkg::CBS_RUN;
					next_s.cnt  = '0;
					next_s.ctx  = s.saved;
					if (!s.started) begin
						next_s.ctx.pc  = s.start_pc;
						next_s.started = 1'b1;
					end
				end
			end
			cbs_pkg::CBS_RUN: begin
				if (exec.done) begin
					next_s.cnt      = s.cnt + 5'h01;
					next_s.ctx.pc   = exec.next_pc;
					next_s.ctx.greg = exec.greg;
					next_s.ctx.equal = exec.equal;
					case (exec.op)
						cbs_pkg::OP_LOAD, cbs_pkg::OP_STORE: begin
							if (s.act.valid) begin
								// range stops at zero, so the flag keeps telling the program the block is spent
								if (s.act.range != '0) begin
									new_range = s.act.range - {{(cbs_pkg::RANGE_W-1){1'b0}}, 1'b1};
								end
								next_s.act.range     = new_range;
								next_s.ctx.last_char = (new_range == '0);
							end
						end
						cbs_pkg::OP_GET_NEXT: begin
							get_next = 1'b1;
							complete = complete || s.act.valid;
						end
						cbs_pkg::OP_CALL: begin
							// a second nested call is not stacked: it runs as a plain jump
							if (!s.call_act) begin
								next_s.ret_pc   = s.ctx.pc + cbs_pkg::PC_STEP;
								next_s.call_act = 1'b1;
							end
						end
						cbs_pkg::OP_RETURN: begin
							if (s.call_act) begin
								next_s.ctx.pc   = s.ret_pc;
								next_s.call_act = 1'b0;
							end
						end
						cbs_pkg::OP_MARK: begin
							next_s.reason = (s.reason & ~cbs_pkg::REASON_MASK)
								| (exec.data & cbs_pkg::REASON_MASK);
						end
						cbs_pkg::OP_KICK: begin
							next_s.partner = (s.partner & ~cbs_pkg::PARTNER_MASK)
								| (exec.data & cbs_pkg::PARTNER_MASK);
							next_s.kick = 1'b1;
						end
						default: ;
					endcase
					// the saved copy is exactly what the next start restores
					if (exec.op == cbs_pkg::OP_WAIT) begin
						next_s.mode  = cbs_pkg::CBS_IDLE;
						next_s.saved = next_s.ctx;
					end else if (next_s.cnt == cbs_pkg::RUN_LIMIT) begin
						next_s.mode  = cbs_pkg::CBS_PAUSE;
						next_s.pcnt  = '0;
						next_s.saved = next_s.ctx;
					end
				end
			end
			cbs_pkg::CBS_PAUSE: begin
				// background scans own these cycles; the program cannot tell it was paused
				next_s.pcnt = s.pcnt + 4'h1;
				if (next_s.pcnt == cbs_pkg::PAUSE_CYCLES) begin
					next_s.mode = cbs_pkg::CBS_RUN;
					next_s.cnt  = '0;
					next_s.ctx  = s.saved;
				end
			end
			default: next_s.mode = cbs_pkg::CBS_IDLE;
		endcase

		// a stop parks a running or paused program with its context saved
		if (host_stop && s.mode != cbs_pkg::CBS_IDLE) begin
			next_s.mode  = cbs_pkg::CBS_IDLE;
			next_s.saved = next_s.ctx;
		end

		if (complete) begin
			next_s.st1 = s.reason & cbs_pkg::REASON_MASK;
			next_s.st1[cbs_pkg::ST1_COMPLETE] = 1'b1;
			next_s.st2 = err2;
			next_s.act.valid = 1'b0;
		end
		if (get_next) begin
			// freeing the next slot lets the host queue the following block at once
			next_s.act       = s.nxt;
			next_s.act.addr  = s.nxt.addr;
			next_s.nxt.valid = 1'b0;
		end

		// registered copies so that every output leaves straight from a flop
		next_s.run        = (next_s.mode == cbs_pkg::CBS_RUN);
		next_s.last_shown = next_s.act.last_block && next_s.act.valid;
	end

	// waitrequest leaves reset high, so nothing is answered before a request is seen
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s         <= '0;
			s.mode    <= cbs_pkg::CBS_IDLE;
			s.waitreq <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata      = s.rdata;
	assign avs_waitrequest   = s.waitreq;
	assign run               = s.run;
	assign run_ctx           = s.ctx;
	assign cb_valid          = s.act.valid;
	assign cb_last_block     = s.last_shown;
	assign partner_kick      = s.kick;
	assign line_register_two = s.partner;
endmodule

// ==== tb/cbs_sequencer_props.sv ====
// port assertions of the channel block sequencer
`timescale 1ns/1ps
module cbs_sequencer_props (
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rst_b,
	// register bus
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic               avs_waitrequest,
	// executor and adapter
	input wire cbs_pkg::cbs_exec_t exec,
	input wire logic               run,
	input wire cbs_pkg::cbs_ctx_t  run_ctx,
	input wire logic               cb_valid,
	input wire logic               cb_last_block,
	input wire logic               adapter_req,
	input wire logic               partner_start,
	input wire logic               partner_kick
);
	logic [4:0]  cnt;
	logic [11:0] ret_pc;
	logic        parked;
	logic        gnb_q;
	wire         fin = run && exec.done;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// parked tells idle after reset or a wait from pause, which look alike at the ports; idle after a host stop leaves it low
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 5'h00;
			ret_pc <= 12'h000;
			parked <= 1'b1;
			gnb_q <= 1'b0;
		end else begin
			gnb_q <= fin && exec.op == cbs_pkg::OP_GET_NEXT;
			cnt <= !run ? 5'h00 : fin ? cnt + 5'h01 : cnt;
			if (fin && exec.op == cbs_pkg::OP_CALL)
				ret_pc <= run_ctx.pc + cbs_pkg::PC_STEP;
			parked <= (fin && exec.op == cbs_pkg::OP_WAIT) || (parked && !run);
		end
	end
	sequence s_pause;
		!run [*4] ##1 run;
	endsequence
	sequence s_kick;
		partner_kick ##1 !partner_kick;
	endsequence
	AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	AST_START: assert property (parked && !run && (adapter_req || partner_start) |=> run)
		else $error("idle channel not started");
	AST_WAIT: assert property (fin && exec.op == cbs_pkg::OP_WAIT |=> !run)
		else $error("wait did not stop the program");
	AST_PAUSE: assert property (fin && cnt == 5'h1e && exec.op != cbs_pkg::OP_WAIT |=> s_pause)
		else $error("pause after run limit wrong");
	AST_CALL: assert property (fin && exec.op == cbs_pkg::OP_RETURN |=> run_ctx.pc == ret_pc)
		else $error("return not after call");
	AST_GNB: assert property ($rose(cb_valid) |-> gnb_q)
		else $error("block became active without get next");
	AST_LB: assert property (cb_last_block |-> cb_valid)
		else $error("last block shown without valid block");
	AST_KICK: assert property (fin && exec.op == cbs_pkg::OP_KICK |=> s_kick)
		else $error("partner kick not a single pulse");
endmodule
bind cbs_sequencer cbs_sequencer_props props (.core_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .exec,
	.run, .run_ctx, .cb_valid, .cb_last_block, .adapter_req, .partner_start, .partner_kick);

// ==== tb/cbs_program_model.sv ====
// channel program stand-in that finishes one instruction per call while run is high
`timescale 1ns/1ps
module cbs_program_model (
	// clock and executor handshake
	input  wire logic              core_clk,
	input  wire logic              run,
	input  wire cbs_pkg::cbs_ctx_t run_ctx,
	output cbs_pkg::cbs_exec_t     exec
);
	initial exec = '0;
	// t of zero falls through; released data is inverted so stale values never look valid
	task automatic step(input cbs_pkg::cbs_op_t op, input logic [7:0] d, input logic [11:0] t, output bit ok);
		int n;
		ok = 1'b0;
		for (n = 0; n < 50 && !ok; n++) begin
			@(posedge core_clk);
			ok = run;
		end
		if (ok) begin
			exec <= '{1'b1, op, (t != 12'h000) ? t : run_ctx.pc + cbs_pkg::PC_STEP, d, d[0], d};
			@(posedge core_clk);
			exec <= '{1'b0, op, exec.next_pc, ~d, 1'b0, ~d};
		end
	endtask
endmodule

// ==== tb/cbs_sequencer_tb_top.sv ====
// directed bench of the channel block sequencer
`timescale 1ns/1ps
module cbs_sequencer_tb_top;
	logic                core_clk, rst_b, avs_read, avs_write, avs_waitrequest, is_receive, char_moved;
	logic                adapter_req, status_change, partner_start, run, cb_valid, cb_last_block, partner_kick;
	logic [5:0]          avs_address;
	logic [31:0]         avs_writedata, avs_readdata, rd_q;
	logic [3:0]          avs_byteenable;
	logic [7:0]          line_register_two;
	logic [11:0]         pc0;
	cbs_pkg::cbs_exec_t  exec;
	cbs_pkg::cbs_ctx_t   run_ctx;
	cbs_pkg::cbs_fault_t fault;
	int                  n_errors, tests_run, n;
	bit                  ok;
	cbs_sequencer dut (
		.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec(exec), .run(run),
		.run_ctx(run_ctx), .cb_valid(cb_valid), .cb_last_block(cb_last_block), .is_receive(is_receive),
		.char_moved(char_moved), .fault(fault), .adapter_req(adapter_req), .status_change(status_change),
		.partner_start(partner_start), .partner_kick(partner_kick), .line_register_two(line_register_two)
	);
	cbs_program_model pm (.core_clk, .run, .run_ctx, .exec);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic hang(input string nm);
		check(nm, 32'h0, 32'h1);
		close_out();
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		for (k = 0; k < 20; k++) begin
			@(posedge core_clk);
			if (!avs_waitrequest)
				break;
		end
		rd_q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		if (k == 20)
			hang("bus answer");
	endtask
	task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
		bus(0, a, 0);
		check(nm, rd_q & m, exp);
	endtask
	task automatic st(input cbs_pkg::cbs_op_t op, input logic [7:0] d, input logic [11:0] t);
		pm.step(op, d, t, ok);
		if (!ok)
			hang("run for step");
	endtask
	// s is adapter_req, status_change, partner_start, char_moved from the top bit down
	task automatic strobe(input logic [3:0] s, input logic [3:0] f);
		@(posedge core_clk);
		{adapter_req, status_change, partner_start, char_moved} <= s;
		fault <= f;
		@(posedge core_clk);
		{adapter_req, status_change, partner_start, char_moved} <= 4'h0;
		fault <= 4'h0;
	endtask
	task automatic wait_run();
		for (n = 0; n < 20 && !run; n++)
			@(posedge core_clk);
		if (!run)
			hang("start");
	endtask
	task automatic t_regs();
		rdc("mode", cbs_pkg::OFS_STAT, '1, 32'h1);
		rdc("block status", cbs_pkg::OFS_CB_STATUS, '1, 32'h0);
		rdc("unmapped", 6'h3c, '1, 32'h0);
		$display("regs ended");
	endtask
	task automatic t_block();
		bus(1, cbs_pkg::OFS_START_PC, 32'h200);
		strobe(4'h8, 4'h0);
		wait_run();
		@(negedge core_clk);
		check("start pc", run_ctx.pc, 32'h200);
		// startup: line registers six and four first, line register two last
		st(cbs_pkg::OP_STEP, 0, 0);
		st(cbs_pkg::OP_STEP, 0, 0);
		st(cbs_pkg::OP_KICK, 0, 0);
		bus(1, cbs_pkg::OFS_NEXT_ADDR, 32'h1000);
		bus(1, cbs_pkg::OFS_NEXT_CTL, 32'h10002);
		st(cbs_pkg::OP_MARK, 8'h20, 0);
		st(cbs_pkg::OP_GET_NEXT, 0, 0);
		st(cbs_pkg::OP_LOAD, 0, 0);
		rdc("range", cbs_pkg::OFS_ACT_RANGE, '1, 32'h1);
		rdc("addr held", cbs_pkg::OFS_ACT_ADDR, '1, 32'h1000);
		strobe(4'h1, 4'h0);
		rdc("addr step", cbs_pkg::OFS_ACT_ADDR, '1, 32'h1001);
		st(cbs_pkg::OP_STORE, 0, 0);
		@(negedge core_clk);
		check("last char set", run_ctx.last_char, 32'h1);
		bus(1, cbs_pkg::OFS_NEXT_CTL, 32'h30003);
		st(cbs_pkg::OP_GET_NEXT, 0, 0);
		@(negedge core_clk);
		check("block valid", cb_valid, 32'h1);
		check("last block", cb_last_block, 32'h1);
		rdc("done status", cbs_pkg::OFS_CB_STATUS, '1, 32'h28);
		st(cbs_pkg::OP_LOAD, 0, 0);
		@(negedge core_clk);
		check("last char clear", run_ctx.last_char, 32'h0);
		$display("block ended");
	endtask
	task automatic t_faults();
		logic [31:0] ex [4] = '{32'h2008, 32'h4008, 32'h8008, 32'h0408};
		for (int i = 0; i < 4; i++) begin
			is_receive <= (i == 3);
			bus(1, cbs_pkg::OFS_NEXT_CTL, 32'h30004);
			st(cbs_pkg::OP_GET_NEXT, 0, 0);
			st(cbs_pkg::OP_LOAD, 0, 0);
			bus(1, cbs_pkg::OFS_CB_STATUS, 32'h0);
			strobe(4'h0, 4'h8 >> i);
			rdc("fault status", cbs_pkg::OFS_CB_STATUS, 32'hff08, ex[i]);
			check("last gated", cb_last_block, 32'h0);
		end
		rdc("residue", cbs_pkg::OFS_ACT_RANGE, '1, 32'h3);
		is_receive <= 0;
		$display("faults ended");
	endtask
	task automatic t_stop();
		bus(1, cbs_pkg::OFS_NEXT_CTL, 32'h10005);
		st(cbs_pkg::OP_GET_NEXT, 0, 0);
		bus(1, cbs_pkg::OFS_CB_STATUS, 32'h0);
		bus(1, cbs_pkg::OFS_CTRL, 32'h2);
		rdc("stop status", cbs_pkg::OFS_CB_STATUS, 32'hff08, 32'h8);
		rdc("stop mode", cbs_pkg::OFS_STAT, 32'h7, 32'h1);
		$display("stop ended");
	endtask
	task automatic t_call();
		bus(1, cbs_pkg::OFS_CTRL, 32'h1);
		wait_run();
		st(cbs_pkg::OP_STEP, 0, 0);
		@(negedge core_clk);
		pc0 = run_ctx.pc;
		st(cbs_pkg::OP_CALL, 0, 12'h300);
		st(cbs_pkg::OP_STEP, 0, 0);
		st(cbs_pkg::OP_RETURN, 0, 12'h7ff);
		@(negedge core_clk);
		check("return pc", run_ctx.pc, pc0 + 12'h001);
		$display("call ended");
	endtask
	task automatic t_wait();
		st(cbs_pkg::OP_WAIT, 8'h5a, 0);
		@(negedge core_clk);
		check("wait stops", run, 32'h0);
		rdc("saved reg", cbs_pkg::OFS_CONTEXT, 32'hff0000, 32'h5a0000);
		bus(1, cbs_pkg::OFS_CTRL, 32'hc);
		strobe(4'h4, 4'h0);
		wait_run();
		@(negedge core_clk);
		check("restored reg", run_ctx.greg, 32'h5a);
		$display("wait ended");
	endtask
	task automatic t_pause();
		repeat (31)
			st(cbs_pkg::OP_STEP, 0, 0);
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (run)
				break;
		end
		check("pause cycles", n, cbs_pkg::PAUSE_CYCLES);
		st(cbs_pkg::OP_KICK, 8'h40, 0);
		@(negedge core_clk);
		check("partner byte", line_register_two, 32'h40);
		check("kick pulse", partner_kick, 32'h1);
		st(cbs_pkg::OP_WAIT, 0, 0);
		strobe(4'h2, 4'h0);
		wait_run();
		$display("pause ended");
	endtask
	initial begin
		rst_b = 0;
		{avs_read, avs_write, is_receive, char_moved, adapter_req, status_change, partner_start} = '0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		fault = 4'h0;
		n_errors = 0;
		tests_run = 0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1;
		t_regs();
		t_block();
		t_faults();
		t_stop();
		t_call();
		t_wait();
		t_pause();
		close_out();
	end
endmodule
